//--- src/efac_pkg.sv
// Package: register map, field positions, reset values and timing counts
package efac_pkg;
	// ****************************************************************
	// Register offsets (byte addresses on the register bus)
	// ****************************************************************
	localparam logic [11:0] OFS_CTRL = 12'h018c;
	localparam logic [11:0] OFS_UNLOCK = 12'h018d;
	localparam logic [11:0] OFS_DATA_LO = 12'h010c;
	localparam logic [11:0] OFS_ADDR_LO = 12'h010d;
	localparam logic [11:0] OFS_DATA_HI = 12'h010e;
	localparam logic [11:0] OFS_ADDR_HI = 12'h010f;
	localparam logic [11:0] OFS_IRQ_FLAGS = 12'h000d;
	// ****************************************************************
	// Control register fields, and the write-done flag of the interrupt flags
	// ****************************************************************
	localparam int BIT_READ_GO = 0;
	localparam int BIT_WRITE_GO = 1;
	localparam int BIT_WRITE_ALLOW = 2;
	localparam int BIT_WRITE_ABORT = 3;
	localparam int BIT_SPACE_SELECT = 7;
	localparam int BIT_WRITE_DONE = 4;
	// ****************************************************************
	// Unlock keys and widths
	// ****************************************************************
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
	localparam int EE_ADDR_W = 8;
	localparam int EE_DEPTH = 256;
	localparam int PM_ADDR_W = 13;
	localparam int PM_DATA_W = 14;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int EE_WRITE_TIME_NS = 4000;
	localparam int EE_WRITE_CYC = EE_WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int PM_READ_CYC = 2;
	localparam int PM_ERASE_CYC = 20;
	localparam int PM_PROG_CYC = 20;
	localparam int TMR_W = 16;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EE_WRITE = 3'b001,
		ST_PM_ERASE = 3'b010,
		ST_PM_PROG = 3'b011,
		ST_PM_READ = 3'b100,
		ST_RELEASE = 3'b101
	} efac_state_e;
endpackage

//--- src/efac_write_timer.sv
// Write timer: counts a loaded number of cycles and pulses when it ends
`timescale 1ns/1ns
module efac_write_timer (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [15:0] i_count,
	output logic o_busy,
	output logic o_done
);
	typedef struct packed {
		logic [15:0] cnt;
		logic busy;
		logic done;
	} efac_tmr_s;
	efac_tmr_s s_q;
	efac_tmr_s s_d;
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (i_load) begin
			s_d.cnt = i_count;
			s_d.busy = 1'b1;
		end else if (s_q.busy) begin
			if (s_q.cnt <= 16'h0001) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.cnt = 16'h0000;
			end else begin
				s_d.cnt = s_q.cnt - 16'h0001;
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign o_busy = s_q.busy;
	assign o_done = s_q.done;
endmodule

//--- src/efac_ee_array.sv
// Data EEPROM array: 256 bytes, synchronous write, combinational read
`timescale 1ns/1ns
module efac_ee_array (
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:efac_pkg::EE_DEPTH-1];
	// Contents survive reset like a real non-volatile store
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end
	assign o_rdata = mem[i_addr];
endmodule

//--- src/efac_ctrl.sv
// Access controller for data EEPROM and program flash, Wishbone slave
`timescale 1ns/1ns
module efac_ctrl (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_por,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_irq_pending,
	output logic o_irq_release,
	output logic o_fetch_stall,
	output logic o_busy,
	output logic o_pm_en,
	output logic o_pm_erase,
	output logic o_pm_prog,
	output logic [12:0] o_pm_addr,
	output logic [13:0] o_pm_wdata,
	input wire logic [13:0] i_pm_rdata
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		efac_pkg::efac_state_e st;
		logic ack;
		logic [31:0] rdat;
		logic space_sel;
		logic write_abort;
		logic write_allow;
		logic write_go;
		logic read_go;
		logic write_done;
		logic [7:0] data_lo;
		logic [5:0] data_hi;
		logic [7:0] addr_lo;
		logic [4:0] addr_hi;
		logic [1:0] unlock;
		logic [1:0] rd_cnt;
		logic ee_we;
		logic held_irq;
		logic release_q;
	} efac_ctrl_s;
	efac_ctrl_s s_q;
	efac_ctrl_s s_d;
	logic tmr_load;
	logic [15:0] tmr_count;
	logic tmr_done;
	logic [7:0] ee_rdata;
	logic acc;
	logic wr;
	logic [7:0] wbyte;
	logic busy;
	// ****************************************************************
	// Submodules
	// ****************************************************************
	// Timer clears on warm reset too, so a cut write stops there
	efac_write_timer u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_busy(),
		.o_done(tmr_done)
	);
	efac_ee_array u_ee (
		.i_clk(i_clk),
		.i_we(s_q.ee_we),
		.i_addr(s_q.addr_lo),
		.i_wdata(s_q.data_lo),
		.o_rdata(ee_rdata)
	);
	// ****************************************************************
	// Bus decode
	// ****************************************************************
	// Ack high blocks a second take of one held request
	assign acc = i_wb_cyc && i_wb_stb && !s_q.ack;
	assign wr = acc && i_wb_we && i_wb_sel[0];
	assign wbyte = i_wb_dat[7:0];
	// Single busy spans every write phase
	assign busy = s_q.st != efac_pkg::ST_IDLE
		&& s_q.st != efac_pkg::ST_PM_READ;
	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		s_d.ack = acc;
		s_d.ee_we = 1'b0;
		s_d.release_q = 1'b0;
		tmr_load = 1'b0;
		tmr_count = 16'h0000;
		// ************************************************************
		// Interrupt holding
		// ************************************************************
		// Events seen while an operation runs wait for the release
		if (i_irq_pending && s_q.st != efac_pkg::ST_IDLE) begin
			s_d.held_irq = 1'b1;
		end
		// ************************************************************
		// Register reads
		// ************************************************************
		if (acc && !i_wb_we) begin
			s_d.rdat = 32'h0000_0000;
			unique case (i_wb_adr)
				efac_pkg::OFS_CTRL: begin
					s_d.rdat[efac_pkg::BIT_SPACE_SELECT] = s_q.space_sel;
					s_d.rdat[efac_pkg::BIT_WRITE_ABORT] = s_q.write_abort;
					s_d.rdat[efac_pkg::BIT_WRITE_ALLOW] = s_q.write_allow;
					s_d.rdat[efac_pkg::BIT_WRITE_GO] = s_q.write_go;
					s_d.rdat[efac_pkg::BIT_READ_GO] = s_q.read_go;
				end
				efac_pkg::OFS_DATA_LO: s_d.rdat[7:0] = s_q.data_lo;
				// Upper two bits fixed at zero
				efac_pkg::OFS_DATA_HI: s_d.rdat[5:0] = s_q.data_hi;
				efac_pkg::OFS_ADDR_LO: s_d.rdat[7:0] = s_q.addr_lo;
				efac_pkg::OFS_ADDR_HI: s_d.rdat[4:0] = s_q.addr_hi;
				efac_pkg::OFS_IRQ_FLAGS: begin
					s_d.rdat[efac_pkg::BIT_WRITE_DONE] = s_q.write_done;
				end
				// Unlock port reads zero, like any unmapped offset
				default: s_d.rdat = 32'h0000_0000;
			endcase
		end
		// ************************************************************
		// Register writes
		// ************************************************************
		// Any write but a correct key resets the unlock position
		if (wr) begin
			unique case (i_wb_adr)
				efac_pkg::OFS_CTRL: begin
					// Select frozen while an operation runs
					if (!busy && s_q.st != efac_pkg::ST_PM_READ
						&& !s_q.read_go) begin
						s_d.space_sel = wbyte[efac_pkg::BIT_SPACE_SELECT];
					end
					s_d.write_abort = wbyte[efac_pkg::BIT_WRITE_ABORT];
					s_d.write_allow = wbyte[efac_pkg::BIT_WRITE_ALLOW];
					// Go bits settable only; zeros are ignored
					if (wbyte[efac_pkg::BIT_READ_GO] && !busy
						&& s_q.st == efac_pkg::ST_IDLE) begin
						s_d.read_go = 1'b1;
					end
					// Allow must already be set; unlock must be armed
					if (wbyte[efac_pkg::BIT_WRITE_GO] && s_q.write_allow
						&& s_q.unlock == 2'b10 && !s_q.write_go) begin
						s_d.write_go = 1'b1;
					end
					s_d.unlock = 2'b00;
				end
				efac_pkg::OFS_UNLOCK: begin
					// Only the sequence position is kept
					if (wbyte == efac_pkg::UNLOCK_KEY_FIRST) begin
						s_d.unlock = 2'b01;
					end else if (wbyte == efac_pkg::UNLOCK_KEY_SECOND
						&& s_q.unlock == 2'b01) begin
						s_d.unlock = 2'b10;
					end else begin
						s_d.unlock = 2'b00;
					end
				end
				efac_pkg::OFS_DATA_LO: begin
					if (!busy) s_d.data_lo = wbyte;
					s_d.unlock = 2'b00;
				end
				efac_pkg::OFS_DATA_HI: begin
					if (!busy) s_d.data_hi = wbyte[5:0];
					s_d.unlock = 2'b00;
				end
				efac_pkg::OFS_ADDR_LO: begin
					if (!busy) s_d.addr_lo = wbyte;
					s_d.unlock = 2'b00;
				end
				efac_pkg::OFS_ADDR_HI: begin
					// Upper bits dropped; software keeps them clear
					if (!busy) s_d.addr_hi = wbyte[4:0];
					s_d.unlock = 2'b00;
				end
				efac_pkg::OFS_IRQ_FLAGS: begin
					if (!wbyte[efac_pkg::BIT_WRITE_DONE]) begin
						s_d.write_done = 1'b0;
					end
					s_d.unlock = 2'b00;
				end
				default: s_d.unlock = 2'b00;
			endcase
		end
		// ************************************************************
		// Operation sequencer; no bulk erase path exists
		// ************************************************************
		unique case (s_q.st)
			efac_pkg::ST_IDLE: begin
				// A pending read is served before a pending write
				if (s_q.read_go && !s_q.space_sel) begin
					// Byte lands in low data next cycle
					s_d.data_lo = ee_rdata;
					s_d.read_go = 1'b0;
				end else if (s_q.read_go) begin
					s_d.st = efac_pkg::ST_PM_READ;
					// Go cycle counts as the first fetch cycle
					s_d.rd_cnt = 2'(efac_pkg::PM_READ_CYC - 2);
				end else if (s_q.write_go && !s_q.space_sel) begin
					s_d.st = efac_pkg::ST_EE_WRITE;
					tmr_load = 1'b1;
					tmr_count = 16'(efac_pkg::EE_WRITE_CYC);
				end else if (s_q.write_go) begin
					s_d.st = efac_pkg::ST_PM_ERASE;
					tmr_load = 1'b1;
					tmr_count = 16'(efac_pkg::PM_ERASE_CYC);
				end
			end
			efac_pkg::ST_PM_READ: begin
				// Two fetch cycles, then the word is visible
				if (s_q.rd_cnt == 2'b00) begin
					s_d.data_lo = i_pm_rdata[7:0];
					s_d.data_hi = i_pm_rdata[13:8];
					s_d.read_go = 1'b0;
					s_d.st = efac_pkg::ST_IDLE;
				end else begin
					s_d.rd_cnt = s_q.rd_cnt - 2'b01;
				end
			end
			efac_pkg::ST_EE_WRITE: begin
				// Write-allow no longer looked at once running
				// Array strobe lands one cycle after the timer ends
				if (tmr_done) begin
					s_d.ee_we = 1'b1;
					s_d.st = efac_pkg::ST_RELEASE;
				end
			end
			efac_pkg::ST_PM_ERASE: begin
				// Program phase follows erase with no software step
				if (tmr_done) begin
					s_d.st = efac_pkg::ST_PM_PROG;
					tmr_load = 1'b1;
					tmr_count = 16'(efac_pkg::PM_PROG_CYC);
				end
			end
			efac_pkg::ST_PM_PROG: begin
				if (tmr_done) begin
					s_d.st = efac_pkg::ST_RELEASE;
				end
			end
			efac_pkg::ST_RELEASE: begin
				// Clear go and set done; done set beats a clear
				s_d.write_go = 1'b0;
				s_d.write_done = 1'b1;
				s_d.release_q = s_q.held_irq || i_irq_pending;
				s_d.held_irq = 1'b0;
				s_d.st = efac_pkg::ST_IDLE;
			end
			default: s_d.st = efac_pkg::ST_IDLE;
		endcase
	end
	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			// Warm reset keeps data, address and select
			s_q.st <= efac_pkg::ST_IDLE;
			s_q.ack <= 1'b0;
			s_q.rdat <= 32'h0000_0000;
			s_q.write_go <= 1'b0;
			s_q.read_go <= 1'b0;
			s_q.unlock <= 2'b00;
			s_q.rd_cnt <= 2'b00;
			s_q.ee_we <= 1'b0;
			s_q.held_irq <= 1'b0;
			s_q.release_q <= 1'b0;
			s_q.write_done <= 1'b0;
			// Assume a cut write; kept as it was if nothing ran
			s_q.write_abort <= 1'b1;
			if (i_por) begin
				// Power-up clears what a warm reset keeps
				s_q.write_allow <= 1'b0;
				s_q.write_abort <= 1'b0;
				s_q.space_sel <= 1'b0;
				s_q.data_lo <= efac_pkg::RESET_BYTE;
				s_q.data_hi <= 6'h00;
				s_q.addr_lo <= efac_pkg::RESET_BYTE;
				s_q.addr_hi <= 5'h00;
			end else if (s_q.st == efac_pkg::ST_IDLE
				|| s_q.st == efac_pkg::ST_PM_READ) begin
				s_q.write_abort <= s_q.write_abort;
			end
		end else begin
			s_q <= s_d;
		end
	end
	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_wb_ack = s_q.ack;
	assign o_wb_dat = s_q.rdat;
	// ****************************************************************
	// Status outputs
	// ****************************************************************
	assign o_busy = busy;
	// Core stalls only on program writes
	assign o_fetch_stall = s_q.st == efac_pkg::ST_PM_ERASE
		|| s_q.st == efac_pkg::ST_PM_PROG
		|| (s_q.st == efac_pkg::ST_RELEASE && s_q.space_sel);
	assign o_irq_release = s_q.release_q;
	// ****************************************************************
	// Program flash side
	// ****************************************************************
	// Array strobes are levels decoded from state
	assign o_pm_en = s_q.st == efac_pkg::ST_PM_READ
		|| s_q.st == efac_pkg::ST_PM_ERASE
		|| s_q.st == efac_pkg::ST_PM_PROG;
	assign o_pm_erase = s_q.st == efac_pkg::ST_PM_ERASE;
	assign o_pm_prog = s_q.st == efac_pkg::ST_PM_PROG;
	assign o_pm_addr = {s_q.addr_hi, s_q.addr_lo};
	assign o_pm_wdata = {s_q.data_hi, s_q.data_lo};
endmodule

//--- bench/efac_ctrl_props.sv
// Checker: bus and write-cycle relations at the controller ports
`timescale 1ns/1ns
module efac_ctrl_props (
	input logic i_clk,
	input logic i_rst,
	input logic i_wb_cyc,
	input logic i_wb_stb,
	input logic [31:0] o_wb_dat,
	input logic o_wb_ack,
	input logic o_irq_release,
	input logic o_fetch_stall,
	input logic o_busy,
	input logic o_pm_erase,
	input logic o_pm_prog,
	input logic [12:0] o_pm_addr
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_ack_single: assert property (
		o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	a_ack_follows: assert property (
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not acknowledged");
	a_dat_upper_zero: assert property (
		o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_stall_busy: assert property (
		o_fetch_stall |-> o_busy) else $error("stall without busy");
	a_erase_stalls: assert property (
		o_pm_erase |-> o_fetch_stall) else $error("erase without stall");
	a_prog_after_erase: assert property (
		$rose(o_pm_prog) |-> $past(o_pm_erase))
		else $error("program without erase");
	a_busy_min: assert property (
		$rose(o_busy) |-> o_busy[*8]) else $error("write too short");
	a_busy_bounded: assert property (
		$rose(o_busy) |-> ##[1:200] !o_busy) else $error("write hangs");
	a_irq_held: assert property (
		o_fetch_stall |-> !o_irq_release)
		else $error("interrupt released during write");
	a_addr_frozen: assert property (
		o_busy |=> $stable(o_pm_addr)) else $error("address moved");
endmodule
bind efac_ctrl efac_ctrl_props u_props (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb),
	.o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack),
	.o_irq_release(o_irq_release),
	.o_fetch_stall(o_fetch_stall),
	.o_busy(o_busy),
	.o_pm_erase(o_pm_erase),
	.o_pm_prog(o_pm_prog),
	.o_pm_addr(o_pm_addr)
);

//--- bench/efac_flash_model.sv
// Flash array model: erase sets ones, programming only clears bits
`timescale 1ns/1ns
module efac_flash_model (
	input wire logic i_clk,
	input wire logic i_en,
	input wire logic i_erase,
	input wire logic i_prog,
	input wire logic [12:0] i_addr,
	input wire logic [13:0] i_wdata,
	output logic [13:0] o_rdata
);
	logic [13:0] mem [0:8191];
	logic tog = 1'b0;
	// Skipped erase shows up as a wrong word
	always @(posedge i_clk) begin
		tog <= ~tog;
		if (i_erase) mem[i_addr] <= 14'h3fff;
		else if (i_prog) mem[i_addr] <= mem[i_addr] & i_wdata;
	end
	// Idle lines toggle so stale data cannot pass
	assign o_rdata = i_en ? mem[i_addr] : {7{tog, ~tog}};
endmodule

//--- bench/tb.sv
// Testbench for the memory access controller
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic irq = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] dat, rd;
	logic ack, busy, stall, pm_en, pm_er, pm_pg, rel;
	logic [12:0] pm_a;
	logic [13:0] pm_wd, pm_rd;
	logic [31:0] rnd = 32'h0000_0f24;
	logic [7:0] ee [0:255];
	logic [7:0] a, ah;
	int failures = 0;
	int n_compared = 0;
	int n_rel = 0;
	int i;
	always #50 clk = ~clk;
	// Held interrupts released, one pulse per finished write that had an interrupt held or pending
	always @(posedge clk) begin
		if (rel === 1'b1) n_rel <= n_rel + 1;
	end
	efac_ctrl u_efac_ctrl (.i_clk(clk), .i_rst(rst), .i_por(por),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack),
		.i_irq_pending(irq), .o_irq_release(rel), .o_fetch_stall(stall),
		.o_busy(busy), .o_pm_en(pm_en), .o_pm_erase(pm_er),
		.o_pm_prog(pm_pg), .o_pm_addr(pm_a), .o_pm_wdata(pm_wd),
		.i_pm_rdata(pm_rd));
	efac_flash_model u_efac_flash_model (.i_clk(clk), .i_en(pm_en),
		.i_erase(pm_er), .i_prog(pm_pg), .i_addr(pm_a), .i_wdata(pm_wd),
		.o_rdata(pm_rd));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] hi_exp(input logic [7:0] d);
		return 32'(d & 8'h3f);
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task results;
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task wb(input logic [11:0] ad, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= 32'(d);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) failures++;
		rd = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rdchk(input logic [11:0] ad, input logic [31:0] e);
		wb(ad, 1'b0, 8'h00);
		chk(rd, e);
	endtask
	task start(input logic [7:0] ad, input logic [7:0] d, input logic [7:0] s);
		wb(efac_pkg::OFS_ADDR_LO, 1'b1, ad);
		wb(efac_pkg::OFS_DATA_LO, 1'b1, d);
		wb(efac_pkg::OFS_CTRL, 1'b1, s | 8'h04);
		wb(efac_pkg::OFS_UNLOCK, 1'b1, 8'h55);
		wb(efac_pkg::OFS_UNLOCK, 1'b1, 8'haa);
		wb(efac_pkg::OFS_CTRL, 1'b1, s | 8'h06);
		repeat (3) @(posedge clk);
	endtask
	task waitdone;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (busy !== 1'b0) failures++;
	endtask
	task eerd(input logic [7:0] ad);
		wb(efac_pkg::OFS_ADDR_LO, 1'b1, ad);
		wb(efac_pkg::OFS_CTRL, 1'b1, 8'h01);
		rdchk(efac_pkg::OFS_DATA_LO, 32'(ee[ad]));
	endtask
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		rdchk(efac_pkg::OFS_CTRL, 32'h0000_0000);
		wb(efac_pkg::OFS_UNLOCK, 1'b1, 8'h55);
		rdchk(efac_pkg::OFS_UNLOCK, 32'h0000_0000);
		rdchk(12'h0ff0, 32'h0000_0000);
		// End addresses first, then random ones
		for (i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd[7:0];
			start(a, rnd[15:8], 8'h00);
			ee[a] = rnd[15:8];
			waitdone();
			rdchk(efac_pkg::OFS_CTRL, 32'h0000_0004);
			rdchk(efac_pkg::OFS_IRQ_FLAGS, 32'h0000_0010);
			wb(efac_pkg::OFS_IRQ_FLAGS, 1'b1, 8'h00);
			eerd(a);
			rdchk(efac_pkg::OFS_CTRL, 32'h0000_0000);
		end
		wb(efac_pkg::OFS_CTRL, 1'b1, 8'h04);
		wb(efac_pkg::OFS_UNLOCK, 1'b1, 8'h55);
		wb(efac_pkg::OFS_DATA_LO, 1'b1, 8'h11);
		wb(efac_pkg::OFS_UNLOCK, 1'b1, 8'haa);
		wb(efac_pkg::OFS_CTRL, 1'b1, 8'h06);
		rdchk(efac_pkg::OFS_CTRL, 32'h0000_0004);
		wb(efac_pkg::OFS_CTRL, 1'b1, 8'h00);
		wb(efac_pkg::OFS_UNLOCK, 1'b1, 8'h55);
		wb(efac_pkg::OFS_UNLOCK, 1'b1, 8'haa);
		wb(efac_pkg::OFS_CTRL, 1'b1, 8'h06);
		rdchk(efac_pkg::OFS_CTRL, 32'h0000_0004);
		start(8'h42, 8'h99, 8'h00);
		ee[8'h42] = 8'h99;
		wb(efac_pkg::OFS_CTRL, 1'b1, 8'h80);
		rdchk(efac_pkg::OFS_CTRL, 32'h0000_0002);
		waitdone();
		eerd(8'h42);
		start(8'h3c, 8'h5a, 8'h00);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdchk(efac_pkg::OFS_CTRL, 32'h0000_000c);
		rdchk(efac_pkg::OFS_ADDR_LO, 32'h0000_003c);
		// Same word twice, so a missing erase corrupts it
		irq <= 1'b1;
		rnd = lfsr(rnd);
		ah = {3'h0, rnd[20:16]};
		a = rnd[7:0];
		for (i = 0; i < 2; i++) begin
			rnd = lfsr(rnd);
			wb(efac_pkg::OFS_ADDR_HI, 1'b1, ah);
			wb(efac_pkg::OFS_DATA_HI, 1'b1, rnd[31:24]);
			start(a, rnd[15:8], 8'h80);
			chk(32'(stall), 32'h0000_0001);
			waitdone();
			wb(efac_pkg::OFS_DATA_LO, 1'b1, 8'h00);
			wb(efac_pkg::OFS_DATA_HI, 1'b1, 8'h00);
			wb(efac_pkg::OFS_CTRL, 1'b1, 8'h81);
			rdchk(efac_pkg::OFS_DATA_HI, hi_exp(rnd[31:24]));
			rdchk(efac_pkg::OFS_DATA_LO, 32'(rnd[15:8]));
		end
		chk(32'(n_rel), 32'h0000_0002);
		results();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end
endmodule
